// ---- dim_host.sv ----
// Host model that drives the dimming input as a logic-level PWM.
`timescale 1ns/1ps
module dim_host (
    input  wire logic        clk_in,
    input  wire logic [15:0] period_in,
    input  wire logic [15:0] high_in,
    output logic             dim_out
);
    logic [15:0] cnt_reg;
    // Start low so the device sees a defined level from time zero.
    initial begin
        cnt_reg = 16'h0000;
        dim_out = 1'b0;
    end
    // Level changes on the falling edge only; high equal to period holds it high.
    always @(negedge clk_in) begin
        cnt_reg <= (cnt_reg + 16'h0001 >= period_in) ? 16'h0000 : cnt_reg + 16'h0001;
        dim_out <= cnt_reg < high_in;
    end
endmodule // dim_host

// ---- led_boost_control_sequencer.sv ----
// Supervisory and sequencing logic for a white-LED boost converter.
// Functional notes
// - Ramp reference in 32 steps, 213us each.
// - Half current limit for first 5ms.
// - Sample open-string indications each switching cycle.
// - Eight cycles overvoltage with low feedback: shutdown.
// - Open-string shutdown holds until dimming toggled.
// - Dimming low over 2.5ms causes shutdown.
// - No switching pulses while shut down.
// - Dimming held high gives full reference.
// - Reference gated in step with dimming.
// - Gated reference low-pass filtered for amplifier.
// - Dimming input used only as logic level.
// - Supply lockout holds switch off.
// - Lockout release restarts automatically.
// - Over-temperature shuts down, releases automatically.
`timescale 1ns/1ps
`include "led_boost_defs.svh"

module led_boost_control_sequencer (
    input  wire logic                     sys_clk_in,
    input  wire logic                     rstn_in,
    input  wire logic                     dim_in,
    input  wire logic                     switch_cycle_in,
    input  wire led_boost_pkg::fault_ind_t fault_in,
    input  wire logic                     pwm_pulse_in,
    output logic                          switch_gate_out,
    output logic                          half_limit_out,
    output logic                          shutdown_out,
    output logic                          open_fault_out,
    output logic [7:0]                    ramp_ref_out,
    output logic [7:0]                    filt_ref_out
);

    led_boost_pkg::seq_state_t state_reg;
    logic        dim_prev_reg;
    logic        open_fault_reg;
    logic        low_off_reg;
    logic [31:0] low_cnt_reg;
    logic [3:0]  open_cnt_reg;
    logic [31:0] step_cnt_reg;
    logic [5:0]  step_idx_reg;
    logic [31:0] half_cnt_reg;
    logic [23:0] lpf_acc_reg;
    logic        dim_rise;
    logic        hold_off;
    logic [7:0]  ramp_ref;
    logic [7:0]  gated_ref;
    logic [24:0] lpf_diff;

    // A rising dimming edge is the only event apart from reset that clears the open-string latch.
    assign dim_rise = dim_in && !dim_prev_reg;
    // Any of these keeps the converter shut down; lockout and thermal are live levels.
    // The latch and the low-time flag are held states, while the two comparator levels
    // release on their own, so lockout and thermal recovery need no host action.
    assign hold_off = open_fault_reg || low_off_reg
                      || fault_in.supply_low_lockout || fault_in.over_temp;

    // Previous dimming level for edge detection.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dim_prev_reg <= 1'b0;
        end else begin
            dim_prev_reg <= dim_in;
        end
    end

    // Low-time shutdown timer; any high level clears it so dimming never accumulates.
    // The flag starts set, so the device waits for a dimming high after reset.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            low_cnt_reg <= 32'h0000_0000;
            low_off_reg <= 1'b1;
        end else if (dim_in) begin
            low_cnt_reg <= 32'h0000_0000;
            low_off_reg <= 1'b0;
        end else if (low_cnt_reg >= `LOW_OFF_CYCLES) begin
            low_off_reg <= 1'b1;
        end else begin
            low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
        end
    end

    // Open-string detector: counts consecutive switching cycles with both indications.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            open_cnt_reg   <= 4'h0;
            open_fault_reg <= 1'b0;
        end else begin
            if (dim_rise) begin
                open_fault_reg <= 1'b0;
            end else if (open_cnt_reg >= `OPEN_CYCLES) begin
                open_fault_reg <= 1'b1;
            end
            if (state_reg == led_boost_pkg::ST_SHUTDOWN || open_cnt_reg >= `OPEN_CYCLES) begin
                open_cnt_reg <= 4'h0;
            end else if (switch_cycle_in) begin
                if (fault_in.switch_node_high && fault_in.sense_feedback_low) begin
                    open_cnt_reg <= open_cnt_reg + 4'h1;
                end else begin
                    open_cnt_reg <= 4'h0;
                end
            end
        end
    end

    // Sequencer: shutdown, soft-start ramp, run; every exit from shutdown restarts ramp.
    // Run is reached only once the ramp and the half-limit window have both completed.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= led_boost_pkg::ST_SHUTDOWN;
        end else begin
            case (state_reg)
                led_boost_pkg::ST_SHUTDOWN: begin
                    if (!hold_off) begin
                        state_reg <= led_boost_pkg::ST_START;
                    end
                end
                led_boost_pkg::ST_START: begin
                    if (hold_off) begin
                        state_reg <= led_boost_pkg::ST_SHUTDOWN;
                    end else if (step_idx_reg >= `STEP_COUNT && half_cnt_reg >= `HALF_LIM_CYCLES) begin
                        state_reg <= led_boost_pkg::ST_RUN;
                    end
                end
                led_boost_pkg::ST_RUN: begin
                    if (hold_off) begin
                        state_reg <= led_boost_pkg::ST_SHUTDOWN;
                    end
                end
                default: state_reg <= led_boost_pkg::ST_SHUTDOWN;
            endcase
        end
    end

    // Soft-start step timer and step index.
    // The index stops at the step count, which also selects the full reference.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            step_cnt_reg <= 32'h0000_0000;
            step_idx_reg <= 6'h00;
        end else if (state_reg == led_boost_pkg::ST_SHUTDOWN) begin
            step_cnt_reg <= 32'h0000_0000;
            step_idx_reg <= 6'h00;
        end else if (step_idx_reg < `STEP_COUNT) begin
            if (step_cnt_reg >= `STEP_CYCLES - 32'd1) begin
                step_cnt_reg <= 32'h0000_0000;
                step_idx_reg <= step_idx_reg + 6'h01;
            end else begin
                step_cnt_reg <= step_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // Half current limit window timer, rearmed by every shutdown.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            half_cnt_reg <= 32'h0000_0000;
        end else if (state_reg == led_boost_pkg::ST_SHUTDOWN) begin
            half_cnt_reg <= 32'h0000_0000;
        end else if (half_cnt_reg < `HALF_LIM_CYCLES) begin
            half_cnt_reg <= half_cnt_reg + 32'h0000_0001;
        end
    end

    // Ramp target: step index scaled to full code, full code once the ramp is done.
    always_comb begin
        if (step_idx_reg >= `STEP_COUNT) begin
            ramp_ref = `REF_FULL;
        end else begin
            ramp_ref = {3'b000, step_idx_reg[4:0]} << `REF_STEP_SHIFT;
        end
    end

    // Reference chopped by the dimming logic level.
    assign gated_ref = dim_in ? ramp_ref : 8'h00;

    // Signed error of the filter; an unsigned shift would turn a falling target into a jump.
    assign lpf_diff = {1'b0, gated_ref, `ZERO16} - {1'b0, lpf_acc_reg};

    // First-order low-pass: acc += (in - acc) >> shift, trades ripple for settling time.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lpf_acc_reg <= 24'h00_0000;
        end else if (state_reg == led_boost_pkg::ST_SHUTDOWN) begin
            lpf_acc_reg <= 24'h00_0000;
        end else begin
            lpf_acc_reg <= lpf_acc_reg + 24'($signed(lpf_diff) >>> `LPF_SHIFT);
        end
    end

    // Switch drive and status flags; the gate is forced low outside active states so a
    // stray pulse from the analog loop can never reach the switch in shutdown.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            switch_gate_out <= 1'b0;
            half_limit_out  <= 1'b1;
            shutdown_out    <= 1'b1;
            open_fault_out  <= 1'b0;
        end else begin
            switch_gate_out <= pwm_pulse_in && !hold_off
                               && state_reg != led_boost_pkg::ST_SHUTDOWN;
            half_limit_out  <= half_cnt_reg < `HALF_LIM_CYCLES;
            shutdown_out    <= state_reg == led_boost_pkg::ST_SHUTDOWN;
            open_fault_out  <= open_fault_reg;
        end
    end

    // Reference codes for the analog side; registered so the converter never sees a
    // combinational glitch when the step index rolls over.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ramp_ref_out    <= 8'h00;
            filt_ref_out    <= 8'h00;
        end else begin
            ramp_ref_out    <= ramp_ref;
            filt_ref_out    <= lpf_acc_reg[23:16];
        end
    end

endmodule // led_boost_control_sequencer

// ---- led_boost_defs.svh ----
// Timing and field constants for the LED boost sequencer.
`ifndef LED_BOOST_DEFS_SVH
`define LED_BOOST_DEFS_SVH

// Clock period in picoseconds (200 MHz).
`define CLK_PERIOD_PS       32'd5000
// Soft-start step hold time in nanoseconds, and the derived cycle count.
`define STEP_TIME_NS        32'd213000
`define STEP_CYCLES         (`STEP_TIME_NS * 32'd1000 / `CLK_PERIOD_PS)
// Number of soft-start steps.
`define STEP_COUNT          6'd32
// Half current limit window in microseconds.
`define HALF_LIM_TIME_US    32'd5000
`define HALF_LIM_CYCLES     (`HALF_LIM_TIME_US * (32'd1000000 / `CLK_PERIOD_PS))
// Low time to shutdown in microseconds (least time, rounds up).
`define LOW_OFF_TIME_US     32'd2500
`define LOW_OFF_CYCLES      ((`LOW_OFF_TIME_US * 32'd1000000 + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
// Consecutive switching cycles of open-string condition before shutdown.
`define OPEN_CYCLES         4'd8
// Full reference code (200 mV scale) and step width of the ramp.
`define REF_FULL            8'hff
`define REF_STEP_SHIFT      3
// Low-pass filter shift (time constant in clock cycles is two to this power).
`define LPF_SHIFT           4'd15
`define ZERO16              16'h0000

`endif

// ---- led_boost_monitor.sv ----
// Concurrent checks on the LED boost sequencer ports.
`timescale 1ns/1ps
module led_boost_monitor (
    input wire logic                      sys_clk_in,
    input wire logic                      rstn_in,
    input wire logic                      dim_in,
    input wire logic                      switch_cycle_in,
    input wire led_boost_pkg::fault_ind_t fault_in,
    input wire logic                      pwm_pulse_in,
    input wire logic                      switch_gate_out,
    input wire logic                      half_limit_out,
    input wire logic                      shutdown_out,
    input wire logic                      open_fault_out,
    input wire logic [7:0]                ramp_ref_out,
    input wire logic [7:0]                filt_ref_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    // Eight sampled cycles of open string while running with dimming already high, so
    // neither an enable edge nor a shutdown clear of the counter intrudes.
    sequence open_run;
        dim_in ##1 (switch_cycle_in && fault_in.switch_node_high
            && fault_in.sense_feedback_low && dim_in && !shutdown_out)[*8];
    endsequence
    // A dimming level with no rising edge in the last four samples.
    sequence steady_dim;
        dim_in[*4];
    endsequence
    // The counter takes the eighth sample, the latch sets one edge later, the port one more.
    chk_open_latch: assert property (open_run ##1 !shutdown_out
        |-> ##2 open_fault_out)
        else $error("open-string latch not set");
    chk_latch_hold: assert property (steady_dim ##0 open_fault_out |=> open_fault_out)
        else $error("open-string latch dropped without enable edge");
    chk_latch_shut: assert property (open_fault_out[*3] |-> shutdown_out)
        else $error("latched open string not shut down");
    chk_lock_shut: assert property ((switch_cycle_in && fault_in.supply_low_lockout)[*5]
        |-> shutdown_out)
        else $error("supply lockout did not shut down");
    chk_temp_shut: assert property ((switch_cycle_in && fault_in.over_temp)[*5]
        |-> shutdown_out)
        else $error("over-temperature did not shut down");
    chk_gate_off: assert property (shutdown_out && $past(shutdown_out)
        |-> !switch_gate_out)
        else $error("switch driven in shutdown");
    // A gate that strays from the pulse is only allowed just ahead of a shutdown.
    chk_gate_follow: assert property (!shutdown_out
        && switch_gate_out != $past(pwm_pulse_in) |-> ##[1:2] shutdown_out)
        else $error("gate does not follow switch pulse");
    chk_restart_soft: assert property ($fell(shutdown_out)
        |-> ramp_ref_out == 8'h00 && half_limit_out)
        else $error("restart without fresh soft start");
endmodule // led_boost_monitor

bind led_boost_control_sequencer led_boost_monitor i_mon (.sys_clk_in, .rstn_in, .dim_in,
    .switch_cycle_in, .fault_in, .pwm_pulse_in, .switch_gate_out, .half_limit_out,
    .shutdown_out, .open_fault_out, .ramp_ref_out, .filt_ref_out);

// ---- led_boost_pkg.sv ----
// Types shared by the LED boost sequencer.
package led_boost_pkg;

    typedef enum logic [1:0] {
        ST_SHUTDOWN,
        ST_START,
        ST_RUN
    } seq_state_t;

    // Analog fault indications; the two open-string ones are sampled once per switching cycle.
    typedef struct packed {
        logic switch_node_high;
        logic sense_feedback_low;
        logic supply_low_lockout;
        logic over_temp;
    } fault_ind_t;

endpackage

// ---- testbench.sv ----
// Self-checking bench for the LED boost sequencer.
`timescale 1ns/1ps
module testbench;
    logic                      clk;
    logic                      rstn;
    logic                      dim;
    logic                      sc;
    logic                      pwm;
    led_boost_pkg::fault_ind_t flt;
    logic [15:0]               per;
    logic [15:0]               hi;
    logic                      gate;
    logic                      half;
    logic                      shut;
    logic                      ofault;
    logic [7:0]                ramp;
    logic [7:0]                filt;
    int                        n_errors = 0;
    int                        cmp_count = 0;
    // Rows: lockout, thermal, pulse, expected shutdown, expected gate.
    logic [4:0]                rows [6] = '{5'h05, 5'h00, 5'h16, 5'h05, 5'h0e, 5'h05};

    led_boost_control_sequencer i_dut (.sys_clk_in(clk), .rstn_in(rstn), .dim_in(dim),
        .switch_cycle_in(sc), .fault_in(flt), .pwm_pulse_in(pwm), .switch_gate_out(gate),
        .half_limit_out(half), .shutdown_out(shut), .open_fault_out(ofault),
        .ramp_ref_out(ramp), .filt_ref_out(filt));
    dim_host i_host (.clk_in(clk), .period_in(per), .high_in(hi), .dim_out(dim));

    // Clock at 200 MHz.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask
    // Both open-string indications for exactly n sampled switching cycles.
    task automatic open_cycles(input int n);
        flt.switch_node_high = 1'b1;
        flt.sense_feedback_low = 1'b1;
        cyc(n);
        flt = '0;
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Cuts a hang short; the limit lies only about 36 us past the roughly 364 us run.
    initial begin
        #400us;
        n_errors++;
        $display("FAIL %0t: run limit reached", $time);
        finish_test();
    end

    // Main sequence; every switching cycle is sampled, so faults land on the next edge.
    initial begin
        rstn = 1'b0;
        sc = 1'b1;
        pwm = 1'b1;
        flt = '0;
        per = 16'h0064;
        hi = 16'h0000;
        cyc(3);
        check({4'h0, gate, half, shut, ofault}, 8'h06);
        check(ramp, 8'h00);
        rstn = 1'b1;
        cyc(20);
        check({7'h00, shut}, 8'h01);
        end_test("reset");
        hi = 16'h0064;
        cyc(10);
        check({6'h00, shut, half}, 8'h01);
        end_test("enable");
        foreach (rows[i]) begin
            {flt.supply_low_lockout, flt.over_temp, pwm} = rows[i][4:2];
            cyc(8);
            check({6'h00, shut, gate}, {6'h00, rows[i][1:0]});
        end
        end_test("fault rows");
        // Dimming at 20 kHz and half duty: each low of 25 us must not time out.
        per = 16'h2710;
        hi = 16'h1388;
        cyc(30000);
        check({6'h00, shut, half}, 8'h01);
        hi = 16'h2710;
        end_test("dimming");
        open_cycles(7);
        cyc(6);
        check({7'h00, ofault}, 8'h00);
        open_cycles(8);
        cyc(6);
        check({6'h00, ofault, shut}, 8'h03);
        flt.supply_low_lockout = 1'b1;
        cyc(6);
        flt = '0;
        cyc(10);
        check({6'h00, ofault, shut}, 8'h03);
        hi = 16'h0000;
        cyc(20);
        hi = 16'h2710;
        cyc(10);
        check({6'h00, ofault, shut}, 8'h00);
        check(ramp, 8'h00);
        check(filt, 8'h00);
        end_test("open string");
        // The first ramp step holds 42600 cycles; look just before and just after it.
        cyc(42588);
        check(ramp, 8'h00);
        cyc(8);
        check(ramp, 8'h08);
        check({7'h00, half}, 8'h01);
        end_test("ramp step");
        finish_test();
    end
endmodule // testbench
